// ---- fwp_pkg.sv ----
package fwp_pkg;
	localparam int CLK_MHZ = 100;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 8;

	// own register map, byte addresses on the software port
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_CONFIG = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RDATA = 8'h14;

	localparam int CFG_BOOT_PROT_BIT = 0;
	localparam int CFG_REISSUE_BIT = 1;
	localparam int CFG_HOLD_RESET_BIT = 2;
	localparam logic [2:0] CONFIG_RST = 3'h2;

	localparam int ST_BUSY_BIT = 0;
	localparam int ST_ABORT_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;
	localparam int ST_SUPPLY_ERR_BIT = 3;
	localparam int ST_TIMEOUT_BIT = 4;
	localparam int ST_PENDING_BIT = 5;
	localparam int ST_SR_LSB = 8;
	localparam int ST_ERR_LSB = 16;

	// device status byte layout
	localparam int SR_READY = 7;
	localparam int SR_ERASE_ERR = 5;
	localparam int SR_WRITE_ERR = 4;
	localparam int SR_SUPPLY_ERR = 3;
	localparam int SR_PROTECT = 1;

	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
	localparam logic [7:0] CMD_LOCK_PERM = 8'hf1;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_WRITE = 3'h1,
		OP_ERASE = 3'h2,
		OP_LOCK_BLOCK = 3'h3,
		OP_LOCK_PERM = 3'h4,
		OP_CLEAR_LOCKS = 3'h5,
		OP_CLEAR_STATUS = 3'h6,
		OP_RESET = 3'h7
	} fwp_op_t;

	// least times, rounded up to whole cycles
	localparam int T_WE_LOW_NS = 50;
	localparam int WE_LOW_CYC = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int T_ACCESS_NS = 100;
	localparam int ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RP_LOW_NS = 100;
	localparam int RP_LOW_CYC = (T_RP_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RP_RECOVER_NS = 1000;
	localparam int RP_RECOVER_CYC = (T_RP_RECOVER_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_STAGES = 2;
endpackage : fwp_pkg

// ---- fwp_cyc_if.sv ----
interface fwp_cyc_if;
	import fwp_pkg::*;
	logic req;
	logic wr;
	logic abort;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic done;
	logic [DATA_W-1:0] rdata;

	modport seq (output req, wr, abort, addr, wdata, input done, rdata);
	modport eng (input req, wr, abort, addr, wdata, output done, rdata);
endinterface : fwp_cyc_if

// ---- fwp_bus_cycle.sv ----
module fwp_bus_cycle import fwp_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rst_n,
	fwp_cyc_if.eng cyc,
	input wire logic [DATA_W-1:0] i_dq,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_dq,
	output logic o_dq_en_n,
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_oe_n
);
	typedef enum logic [2:0] {
		E_IDLE = 3'b000,
		E_SETUP = 3'b001,
		E_PULSE = 3'b011,
		E_HOLD = 3'b010,
		E_READ = 3'b110
	} fwp_eng_t;

	fwp_eng_t st_q;
	logic [7:0] cnt_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] data_q;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] dq_m_q;
	logic [DATA_W-1:0] dq_s_q;
	logic done_q;
	logic ce_n_q;
	logic we_n_q;
	logic oe_n_q;
	logic dq_en_n_q;

	// data bus is asynchronous to us
	always_ff @(posedge i_clock) begin
		dq_m_q <= i_dq;
		dq_s_q <= dq_m_q;
	end

	always_ff @(posedge i_clock) begin
		done_q <= 1'b0;
		if (!i_rst_n || cyc.abort) begin
			st_q <= E_IDLE;
			cnt_q <= 8'h00;
			ce_n_q <= 1'b1;
			we_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			dq_en_n_q <= 1'b1;
			if (!i_rst_n) begin
				addr_q <= '0;
				data_q <= '0;
				rdata_q <= '0;
			end
		end else begin
			case (st_q)
				E_IDLE: begin
					if (cyc.req) begin
						addr_q <= cyc.addr;
						data_q <= cyc.wdata;
						ce_n_q <= 1'b0;
						cnt_q <= 8'h00;
						if (cyc.wr) begin
							dq_en_n_q <= 1'b0;
							st_q <= E_SETUP;
						end else begin
							oe_n_q <= 1'b0;
							st_q <= E_READ;
						end
					end
				end
				E_SETUP: begin
					we_n_q <= 1'b0; // write enable low one cycle after chip enable
					st_q <= E_PULSE;
				end
				E_PULSE: begin
					if (cnt_q == 8'(WE_LOW_CYC - 1)) begin
						we_n_q <= 1'b1;
						st_q <= E_HOLD;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				E_HOLD: begin
					// data held one cycle past the rising write edge
					ce_n_q <= 1'b1;
					dq_en_n_q <= 1'b1;
					done_q <= 1'b1;
					st_q <= E_IDLE;
				end
				E_READ: begin
					if (cnt_q == 8'(ACCESS_CYC + SYNC_STAGES - 1)) begin
						rdata_q <= dq_s_q;
						ce_n_q <= 1'b1;
						oe_n_q <= 1'b1;
						done_q <= 1'b1;
						st_q <= E_IDLE;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				default: st_q <= E_IDLE;
			endcase
		end
	end

	assign cyc.done = done_q;
	assign cyc.rdata = rdata_q;
	assign o_addr = addr_q;
	assign o_dq = data_q;
	assign o_dq_en_n = dq_en_n_q;
	assign o_ce_n = ce_n_q;
	assign o_we_n = we_n_q;
	assign o_oe_n = oe_n_q;
endmodule : fwp_bus_cycle

// ---- fwp_host.sv ----
// Behaviour
// - controller reissues the whole sequence of an operation aborted by reset; here only an altering one cut off in its confirm or poll step.
// - commands accepted only with chip and write enable both low.
// - altering commands are a setup write then a confirm write.
// - host keeps reset pin low through power-up and power-down.
// - host writes read-array command after each altering operation.
//
// Local design decisions: the address-and-strobe port and the register addresses.
module fwp_host import fwp_pkg::*; #(
	parameter logic [7:0] ERASE_SETUP_CODE = 8'h20,
	parameter logic [7:0] CLEAR_STATUS_CODE = 8'h50,
	parameter int POLL_LIMIT = 4000
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_power_good,
	output logic [ADDR_W-1:0] o_fl_addr,
	output logic [DATA_W-1:0] o_fl_dq,
	output logic o_fl_dq_en_n,
	input wire logic [DATA_W-1:0] i_fl_dq,
	output logic o_fl_ce_n,
	output logic o_fl_we_n,
	output logic o_fl_oe_n,
	output logic o_fl_rp_n,
	output logic o_fl_wp_n
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_CONFIRM = 3'b011,
		ST_POLL = 3'b010,
		ST_FINISH = 3'b110,
		ST_READ = 3'b111,
		ST_RST_LOW = 3'b101,
		ST_RST_REC = 3'b100
	} fwp_state_t;

	fwp_cyc_if cyc();

	fwp_bus_cycle u_cycle (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.cyc(cyc),
		.i_dq(i_fl_dq),
		.o_addr(o_fl_addr),
		.o_dq(o_fl_dq),
		.o_dq_en_n(o_fl_dq_en_n),
		.o_ce_n(o_fl_ce_n),
		.o_we_n(o_fl_we_n),
		.o_oe_n(o_fl_oe_n)
	);

	fwp_state_t state_q;
	fwp_state_t next_after;
	fwp_op_t op_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic [2:0] cfg_q;
	logic [DATA_W-1:0] sr_q;
	logic [3:0] err_q;
	logic [DATA_W-1:0] rdata_q;
	logic [31:0] rd_q;
	logic [7:0] cnt_q;
	logic [31:0] poll_q;
	logic issued_q, req_q, aborted_q, pending_q, refused_q, timeout_q;
	logic pg_m_q, pg_s_q;
	logic hold_reset, idle, start, altering, in_flight, rec_done, poll_ready;
	logic [DATA_W-1:0] cyc_data;
	logic [31:0] status_word;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			pg_m_q <= 1'b0;
			pg_s_q <= 1'b0;
		end else begin
			pg_m_q <= i_power_good;
			pg_s_q <= pg_m_q;
		end
	end

	// power fail or software hold both pin the device in reset
	assign hold_reset = cfg_q[CFG_HOLD_RESET_BIT] | ~pg_s_q;
	assign idle = (state_q == ST_IDLE);
	assign start = i_wr && (i_addr == REG_CMD) && idle;
	assign altering = (op_q != OP_READ) && (op_q != OP_CLEAR_STATUS) && (op_q != OP_RESET);
	assign in_flight = altering && ((state_q == ST_CONFIRM) || (state_q == ST_POLL));
	assign rec_done = (state_q == ST_RST_REC) && (cnt_q == 8'(RP_RECOVER_CYC - 1));
	assign poll_ready = cyc.rdata[SR_READY]; // ready bit high means engine idle

	always_comb begin
		next_after = ST_IDLE;
		case (state_q)
			ST_SETUP: begin
				if (op_q == OP_CLEAR_STATUS) begin
					next_after = ST_FINISH;
				end else if (op_q == OP_READ) begin
					next_after = ST_READ;
				end else begin
					next_after = ST_CONFIRM; // second step of the pair
				end
			end
			ST_CONFIRM: next_after = ST_POLL;
			// give up only on a finished read, so no engine cycle is cut short
			ST_POLL: next_after = (poll_ready || timeout_q) ? ST_FINISH : ST_POLL;
			ST_FINISH: next_after = ST_IDLE;
			ST_READ: next_after = ST_IDLE;
			default: next_after = ST_IDLE;
		endcase
	end

	always_comb begin
		cyc_data = CMD_READ_ARRAY;
		case (state_q)
			ST_SETUP: begin
				case (op_q)
					OP_WRITE: cyc_data = CMD_WRITE_SETUP;
					OP_ERASE: cyc_data = ERASE_SETUP_CODE;
					OP_LOCK_BLOCK, OP_LOCK_PERM, OP_CLEAR_LOCKS: cyc_data = CMD_LOCK_SETUP;
					OP_CLEAR_STATUS: cyc_data = CLEAR_STATUS_CODE;
					default: cyc_data = CMD_READ_ARRAY;
				endcase
			end
			ST_CONFIRM: begin
				case (op_q)
					OP_WRITE: cyc_data = wdata_q;
					OP_LOCK_BLOCK: cyc_data = CMD_LOCK_BLOCK;
					OP_LOCK_PERM: cyc_data = CMD_LOCK_PERM;
					default: cyc_data = CMD_CONFIRM;
				endcase
			end
			default: cyc_data = CMD_READ_ARRAY; // leave device in array reads
		endcase
	end

	assign cyc.req = req_q;
	assign cyc.wr = (state_q != ST_POLL) && (state_q != ST_READ);
	assign cyc.addr = addr_q;
	assign cyc.wdata = cyc_data;
	// bus cycles dropped while the reset pin is low
	assign cyc.abort = hold_reset || (state_q == ST_RST_LOW);
	assign o_fl_rp_n = (state_q != ST_RST_LOW);
	assign o_fl_wp_n = ~cfg_q[CFG_BOOT_PROT_BIT]; // boot blocks guarded by pin

	always_ff @(posedge i_clock) begin
		req_q <= 1'b0;
		if (!i_rst_n) begin
			state_q <= ST_RST_LOW; // reset pin low from power-up
			cnt_q <= 8'h00;
			issued_q <= 1'b0;
		end else if (hold_reset && (state_q != ST_RST_LOW)) begin
			state_q <= ST_RST_LOW;
			cnt_q <= 8'h00;
			issued_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						cnt_q <= 8'h00;
						state_q <= (fwp_op_t'(i_wdata[2:0]) == OP_RESET) ? ST_RST_LOW : ST_SETUP;
					end
				end
				ST_SETUP, ST_CONFIRM, ST_POLL, ST_FINISH, ST_READ: begin
					if (!issued_q) begin
						req_q <= 1'b1;
						issued_q <= 1'b1;
					end else if (cyc.done) begin
						issued_q <= 1'b0;
						state_q <= next_after;
					end
				end
				ST_RST_LOW: begin
					if (cnt_q != 8'(RP_LOW_CYC - 1)) begin
						cnt_q <= cnt_q + 8'h01;
					end else if (!hold_reset) begin
						cnt_q <= 8'h00;
						state_q <= ST_RST_REC;
					end
				end
				ST_RST_REC: begin
					// no polling until the device's reset has run out; array reads follow
					if (rec_done) begin
						cnt_q <= 8'h00;
						state_q <= pending_q ? ST_SETUP : ST_IDLE; // reissue from setup
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				default: state_q <= ST_RST_LOW;
			endcase
		end
	end

	// poll watchdog: a stuck device would otherwise hang the sequencer
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || start) begin
			poll_q <= 32'h0;
			timeout_q <= 1'b0;
		end else if (state_q == ST_POLL && !timeout_q) begin
			poll_q <= poll_q + 32'h1;
			if (poll_q == 32'(POLL_LIMIT - 1)) begin
				timeout_q <= 1'b1;
			end
		end else if (state_q == ST_FINISH) begin
			poll_q <= 32'h0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			aborted_q <= 1'b0;
			pending_q <= 1'b0;
		end else if (hold_reset && in_flight) begin
			aborted_q <= 1'b1; // interrupted work is flagged; reissued only if the reissue bit is set
			pending_q <= cfg_q[CFG_REISSUE_BIT];
		end else if (start) begin
			aborted_q <= 1'b0;
			pending_q <= 1'b0;
		end else if (rec_done) begin
			pending_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n || state_q == ST_RST_LOW) begin
			sr_q <= '0; // device status is lost with the reset pin
			err_q <= 4'h0;
		end else if (state_q == ST_POLL && cyc.done) begin
			sr_q <= cyc.rdata;
			if (poll_ready) begin
				// protect bit covers lock bits, boot pin and permanent lock
				// supply bit covers program lockout
				err_q <= err_q | {cyc.rdata[SR_ERASE_ERR], cyc.rdata[SR_WRITE_ERR],
					cyc.rdata[SR_SUPPLY_ERR], cyc.rdata[SR_PROTECT]};
			end
		end else if (state_q == ST_SETUP && op_q == OP_CLEAR_STATUS && cyc.done) begin
			sr_q <= '0;
			err_q <= 4'h0; // clear-status and the reset pin drop the sticky errors
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rdata_q <= '0;
		end else if (state_q == ST_READ && cyc.done) begin
			rdata_q <= cyc.rdata;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			op_q <= OP_READ;
			addr_q <= '0;
			wdata_q <= '0;
			cfg_q <= CONFIG_RST;
		end else if (i_wr) begin
			// operands frozen while a sequence runs
			if (start) begin
				op_q <= fwp_op_t'(i_wdata[2:0]);
			end
			if (i_addr == REG_ADDR && idle) begin
				addr_q <= i_wdata[ADDR_W-1:0];
			end
			if (i_addr == REG_WDATA && idle) begin
				wdata_q <= i_wdata[DATA_W-1:0];
			end
			if (i_addr == REG_CONFIG) begin
				cfg_q <= i_wdata[2:0];
			end
		end
	end

	// refused writes stick; a new refusal beats the clear
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			refused_q <= 1'b0;
		end else if (i_wr && !idle && (i_addr == REG_CMD || i_addr == REG_ADDR
			|| i_addr == REG_WDATA)) begin
			refused_q <= 1'b1;
		end else if (i_wr && i_addr == REG_STATUS && i_wdata[ST_REFUSED_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	always_comb begin
		status_word = 32'h0;
		status_word[ST_BUSY_BIT] = ~idle;
		status_word[ST_ABORT_BIT] = aborted_q;
		status_word[ST_REFUSED_BIT] = refused_q;
		// supply fault only counts alongside an operation error
		status_word[ST_SUPPLY_ERR_BIT] = err_q[1] & (err_q[3] | err_q[2]);
		status_word[ST_TIMEOUT_BIT] = timeout_q;
		status_word[ST_PENDING_BIT] = pending_q;
		status_word[ST_SR_LSB +: DATA_W] = sr_q;
		status_word[ST_ERR_LSB +: 4] = err_q;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rd_q <= 32'h0;
		end else if (i_rd) begin
			case (i_addr)
				REG_CMD: rd_q <= {29'h0, op_q};
				REG_ADDR: rd_q <= 32'(addr_q);
				REG_WDATA: rd_q <= 32'(wdata_q);
				REG_CONFIG: rd_q <= {29'h0, cfg_q};
				REG_STATUS: rd_q <= status_word;
				REG_RDATA: rd_q <= 32'(rdata_q);
				default: rd_q <= 32'h0;
			endcase
		end else begin
			rd_q <= 32'h0;
		end
	end

	assign o_rdata = rd_q;
endmodule : fwp_host

// ---- fwp_host_properties.sv ----
module fwp_host_properties import fwp_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_power_good,
	input wire logic [ADDR_W-1:0] o_fl_addr,
	input wire logic [DATA_W-1:0] o_fl_dq,
	input wire logic o_fl_dq_en_n,
	input wire logic o_fl_ce_n,
	input wire logic o_fl_we_n,
	input wire logic o_fl_oe_n,
	input wire logic o_fl_rp_n
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	chk_quiet_reset_pin: assert property (!o_fl_rp_n
		|-> o_fl_we_n && o_fl_ce_n && o_fl_oe_n)
		else $error("flash strobe active while reset pin low");
	chk_rp_after_reset: assert property ($rose(i_rst_n) |-> !o_fl_rp_n [*8])
		else $error("reset pin released too early");
	chk_power_fail_rp: assert property ($fell(i_power_good) |-> ##[1:5] !o_fl_rp_n)
		else $error("power fail did not pull reset pin low");
	chk_we_inside_ce: assert property (!o_fl_we_n |-> !o_fl_ce_n && o_fl_oe_n)
		else $error("write strobe without chip enable");
	chk_we_pulse_width: assert property ($fell(o_fl_we_n)
		|-> !o_fl_we_n [*5] ##1 o_fl_we_n)
		else $error("write strobe width wrong");
	chk_drive_on_write: assert property (!o_fl_we_n |-> !o_fl_dq_en_n)
		else $error("data not driven during write strobe");
	chk_no_contention: assert property (!o_fl_oe_n |-> o_fl_dq_en_n)
		else $error("data driven while output enabled");
	chk_write_stable: assert property (!o_fl_we_n && !$past(o_fl_we_n)
		|-> $stable(o_fl_dq) && $stable(o_fl_addr))
		else $error("address or data moved during write strobe");
	chk_ce_after_we: assert property ($rose(o_fl_we_n)
		|-> !o_fl_ce_n ##1 o_fl_ce_n && o_fl_dq_en_n)
		else $error("chip enable not held past write strobe");
endmodule : fwp_host_properties

bind fwp_host fwp_host_properties i_props (.i_clock(i_clock), .i_rst_n(i_rst_n),
	.i_power_good(i_power_good), .o_fl_addr(o_fl_addr), .o_fl_dq(o_fl_dq),
	.o_fl_dq_en_n(o_fl_dq_en_n), .o_fl_ce_n(o_fl_ce_n), .o_fl_we_n(o_fl_we_n),
	.o_fl_oe_n(o_fl_oe_n), .o_fl_rp_n(o_fl_rp_n));

// ---- fwp_flash_model.sv ----
module fwp_flash_model import fwp_pkg::*; #(
	parameter int BUSY_CYC = 40,
	parameter int REC_CYC = 20,
	parameter logic [3:0] BOOT_LO = 4'he,
	parameter logic [7:0] ERASE_CODE = 8'h20,
	parameter logic [7:0] CLEAR_CODE = 8'h50
) (
	input wire logic i_clock,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_dq,
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic i_rp_n,
	input wire logic i_wp_n,
	input wire logic i_supply_ok,
	output logic [DATA_W-1:0] o_dq
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem_q [256];
	logic [15:0] locks_q = 16'h0;
	logic perm_q = 1'b0;
	logic array_q = 1'b1;
	logic we_q = 1'b1;
	logic wr_pend = 1'b0;
	logic [7:0] pend_q = 8'h0, sr_q = 8'h0, last_q = 8'h0, d_q, wr_idx, wr_dat, idx;
	logic [ADDR_W-1:0] a_q;
	int busy_q = 0;
	int rec_q = 0;
	logic [7:0] srd;
	// small array: block in the high nibble, byte offset in the low one
	assign idx = {a_q[19:16], a_q[3:0]};
	assign srd = {busy_q == 0 && rec_q == 0, sr_q[6:0]};
	// released bus shows the inverse so a stale byte never passes
	assign o_dq = (!i_ce_n && !i_oe_n && i_rp_n) ?
		(array_q ? mem_q[{i_addr[19:16], i_addr[3:0]}] : srd) : ~last_q;
	initial for (int i = 0; i < 256; i++)
		mem_q[i] = 8'hff;
	function automatic logic prot(input logic [3:0] b);
		return locks_q[b] || (!i_wp_n && b >= BOOT_LO);
	endfunction : prot
	task automatic do_cmd(input logic [7:0] c);
		logic [3:0] b;
		logic [7:0] e;
		b = a_q[19:16];
		e = i_supply_ok ? 8'h00 : 8'h08;
		if (pend_q != 8'h0) begin
			if (pend_q != CMD_LOCK_SETUP && e == 8'h0 && prot(b))
				e = 8'h02;
			if (pend_q == CMD_LOCK_SETUP && c != CMD_LOCK_PERM && e == 8'h0 && perm_q)
				e = 8'h02;
			if (e != 8'h0)
				sr_q = sr_q | e | ((pend_q == ERASE_CODE || (pend_q == CMD_LOCK_SETUP &&
					c == CMD_CONFIRM)) ? 8'h20 : 8'h10);
			else if (pend_q == CMD_WRITE_SETUP) begin
				wr_pend = 1'b1;
				wr_idx = idx;
				wr_dat = c;
			end else if (pend_q == ERASE_CODE)
				for (int i = 0; i < 16; i++)
					mem_q[{b, 4'(i)}] = 8'hff;
			else if (c == CMD_LOCK_BLOCK)
				locks_q[b] = 1'b1;
			else if (c == CMD_LOCK_PERM)
				perm_q = 1'b1;
			else
				locks_q = 16'h0;
			pend_q = 8'h0;
			busy_q = BUSY_CYC;
		end else if (c == CMD_READ_ARRAY)
			array_q = 1'b1;
		else if (c == CLEAR_CODE)
			sr_q = 8'h0;
		else if (c == CMD_READ_STATUS)
			array_q = 1'b0;
		else if (c == CMD_WRITE_SETUP || c == ERASE_CODE || c == CMD_LOCK_SETUP) begin
			pend_q = c;
			array_q = 1'b0;
		end
	endtask : do_cmd
	always @(posedge i_clock) begin
		if (!i_rp_n) begin
			sr_q = 8'h0;
			busy_q = 0;
			rec_q = REC_CYC;
			pend_q = 8'h0;
			wr_pend = 1'b0;
			array_q = 1'b1;
		end else begin
			if (rec_q > 0)
				rec_q--;
			// data lands only at the end, so an abort leaves the old byte
			if (busy_q == 1 && wr_pend) begin
				mem_q[wr_idx] = wr_dat;
				wr_pend = 1'b0;
			end
			if (busy_q > 0)
				busy_q--;
			if (!we_q && i_we_n && !i_ce_n && rec_q == 0)
				do_cmd(d_q);
		end
		if (!i_ce_n && !i_oe_n && i_rp_n)
			last_q = o_dq;
		we_q = i_we_n;
		d_q = i_dq;
		a_q = i_addr;
	end
endmodule : fwp_flash_model

// ---- tb_fwp_host.sv ----
module tb_fwp_host;
	timeunit 1ns;
	timeprecision 100ps;
	import fwp_pkg::*;
	logic i_clock = 1'b0;
	logic i_rst_n, i_wr, i_rd, i_power_good, supply_ok;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata;
	logic [ADDR_W-1:0] fl_addr;
	logic [DATA_W-1:0] fl_dq, dev_dq, bus_dq;
	logic dq_en_n, ce_n, we_n, oe_n, rp_n, wp_n;
	int miscompares = 0;
	int cmp_count = 0;
	assign bus_dq = dq_en_n ? dev_dq : fl_dq;
	fwp_host #(.POLL_LIMIT(200)) i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_power_good(i_power_good),
		.o_fl_addr(fl_addr), .o_fl_dq(fl_dq), .o_fl_dq_en_n(dq_en_n), .i_fl_dq(bus_dq),
		.o_fl_ce_n(ce_n), .o_fl_we_n(we_n), .o_fl_oe_n(oe_n), .o_fl_rp_n(rp_n), .o_fl_wp_n(wp_n));
	fwp_flash_model i_model (.i_clock(i_clock), .i_addr(fl_addr), .i_dq(bus_dq), .i_ce_n(ce_n),
		.i_we_n(we_n), .i_oe_n(oe_n), .i_rp_n(rp_n), .i_wp_n(wp_n), .i_supply_ok(supply_ok),
		.o_dq(dev_dq));
	initial forever #5 i_clock = ~i_clock;
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task final_report;
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : reg_wr
	task reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : reg_rd
	task wait_idle;
		logic [31:0] s;
		for (int n = 0; n < 400; n++) begin
			reg_rd(REG_STATUS, s);
			if (s[ST_BUSY_BIT] === 1'b0)
				return;
		end
		miscompares++;
		final_report();
	endtask : wait_idle
	task wait_rp_low;
		for (int n = 0; n < 40; n++) begin
			@(posedge i_clock);
			if (rp_n === 1'b0)
				return;
		end
		miscompares++;
		final_report();
	endtask : wait_rp_low
	task op(input logic [19:0] a, input logic [7:0] d, input logic [2:0] code);
		reg_wr(REG_ADDR, {12'h0, a});
		reg_wr(REG_WDATA, {24'h0, d});
		reg_wr(REG_CMD, {29'h0, code});
		wait_idle();
	endtask : op
	task errs(input logic [3:0] e);
		logic [31:0] s;
		reg_rd(REG_STATUS, s);
		check("sticky errors", {28'h0, s[19:16]}, {28'h0, e});
	endtask : errs
	task s_reset;
		logic [31:0] s;
		reg_rd(REG_CONFIG, s);
		check("config reset", s, 32'h2);
		check("boot pin", wp_n, 1'b1);
		reg_wr(8'h20, 32'hffffffff);
		reg_rd(8'h20, s);
		check("unmapped", s, 32'h0);
		wait_idle();
		check("array mode", i_model.array_q, 1'b1);
	endtask : s_reset
	task s_write;
		logic [31:0] s;
		reg_wr(REG_ADDR, 32'h10003);
		reg_wr(REG_WDATA, 32'h5a);
		reg_wr(REG_CMD, 32'h1);
		reg_wr(REG_CMD, 32'h1);
		reg_rd(REG_STATUS, s);
		check("refused", s[ST_REFUSED_BIT], 1'b1);
		wait_idle();
		reg_wr(REG_STATUS, 32'h4);
		reg_rd(REG_STATUS, s);
		check("refused clear", s[ST_REFUSED_BIT], 1'b0);
		check("written", i_model.mem_q[8'h13], 8'h5a);
		check("array mode", i_model.array_q, 1'b1);
		errs(4'h0);
		op(20'h10003, 8'h0, 3'h0);
		reg_rd(REG_RDATA, s);
		check("array read", s, 32'h5a);
		op(20'h10000, 8'h0, 3'h2);
		check("erased", i_model.mem_q[8'h13], 8'hff);
	endtask : s_write
	task s_supply;
		logic [31:0] s;
		supply_ok <= 1'b0;
		op(20'h20001, 8'h11, 3'h1);
		reg_rd(REG_STATUS, s);
		check("supply flag", s[ST_SUPPLY_ERR_BIT], 1'b1);
		errs(4'h6);
		check("locked out", i_model.mem_q[8'h21], 8'hff);
		supply_ok <= 1'b1;
		op(20'h20001, 8'h11, 3'h1);
		errs(4'h6);
		check("written", i_model.mem_q[8'h21], 8'h11);
		op(20'h0, 8'h0, 3'h6);
		errs(4'h0);
	endtask : s_supply
	task s_locks;
		op(20'h30000, 8'h0, 3'h3);
		op(20'h30005, 8'h77, 3'h1);
		errs(4'h5);
		op(20'h0, 8'h0, 3'h6);
		op(20'h0, 8'h0, 3'h5);
		reg_wr(REG_CONFIG, 32'h3);
		op(20'hf0002, 8'h33, 3'h1);
		check("boot pin", wp_n, 1'b0);
		errs(4'h5);
		op(20'h0, 8'h0, 3'h6);
		op(20'h30005, 8'h44, 3'h1);
		errs(4'h0);
		check("unlocked", i_model.mem_q[8'h35], 8'h44);
		op(20'h0, 8'h0, 3'h4);
		op(20'h50000, 8'h0, 3'h3);
		errs(4'h5);
		op(20'h0, 8'h0, 3'h6);
		reg_wr(REG_CONFIG, 32'h2);
	endtask : s_locks
	task s_abort;
		logic [31:0] s;
		supply_ok <= 1'b0;
		op(20'h0, 8'h0, 3'h1);
		supply_ok <= 1'b1;
		reg_wr(REG_ADDR, 32'h40002);
		reg_wr(REG_WDATA, 32'ha5);
		reg_wr(REG_CMD, 32'h1);
		for (int n = 0; n < 80 && i_model.busy_q == 0; n++)
			@(posedge i_clock);
		if (i_model.busy_q == 0) begin
			miscompares++;
			final_report();
		end
		reg_wr(REG_CONFIG, 32'h6);
		wait_rp_low();
		reg_rd(REG_STATUS, s);
		check("status cleared", s[19:8], 12'h0);
		check("pending", s[ST_PENDING_BIT], 1'b1);
		check("aborted data", i_model.mem_q[8'h42], 8'hff);
		reg_wr(REG_CONFIG, 32'h2);
		// low time and recovery are fixed counts, not a handshake
		repeat (120) @(posedge i_clock);
		wait_idle();
		reg_rd(REG_STATUS, s);
		check("abort flag", s[ST_ABORT_BIT], 1'b1);
		check("reissued", i_model.mem_q[8'h42], 8'ha5);
		check("array mode", i_model.array_q, 1'b1);
		@(posedge i_clock);
		i_power_good <= 1'b0;
		wait_rp_low();
		i_power_good <= 1'b1;
		repeat (120) @(posedge i_clock);
		wait_idle();
		reg_wr(REG_CMD, 32'h7);
		wait_rp_low();
		repeat (120) @(posedge i_clock);
		wait_idle();
		check("array mode", i_model.array_q, 1'b1);
	endtask : s_abort
	initial begin
		i_rst_n = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h0;
		i_wdata = 32'h0;
		i_power_good = 1'b1;
		supply_ok = 1'b1;
		repeat (5) @(posedge i_clock);
		check("reset pin held", rp_n, 1'b0);
		i_rst_n <= 1'b1;
		s_reset();
		s_write();
		s_supply();
		s_locks();
		s_abort();
		final_report();
	end
endmodule : tb_fwp_host
